// >>> shared/irq_pkg.sv
// constants, field layouts and carrier types of the interrupt controller
package irq_pkg;
	localparam int NUM_SRC = 15;
	localparam int IDX_W = 5;
	localparam int REG_W = 8;

	// register byte addresses on the AXI4-Lite slave
	localparam logic [7:0] OFS_ENABLE = 8'hA8;
	localparam logic [7:0] OFS_PRIORITY = 8'hB8;
	localparam logic [7:0] OFS_EXT_ENABLE = 8'hE8;
	localparam logic [7:0] OFS_EXT_PRIORITY = 8'hF8;
	localparam logic [7:0] OFS_EXT_FLAG = 8'h90;
	localparam logic [7:0] OFS_CONTROL = 8'hC0;
	localparam logic [7:0] OFS_LOCAL_FLAG = 8'hC4;
	localparam logic [7:0] OFS_DEBUG_ID = 8'hC8;
	localparam logic [7:0] OFS_STATUS = 8'hCC;

	// reset values
	localparam logic [7:0] RST_ENABLE = 8'h00;
	localparam logic [7:0] RST_PRIORITY = 8'h00;
	localparam logic [7:0] RST_EXT_ENABLE = 8'h00;
	localparam logic [7:0] RST_EXT_PRIORITY = 8'h00;
	localparam logic [7:0] RST_DEBUG_ID = 8'h00;

	// field positions
	localparam int ENABLE_GLOBAL_BIT = 7;
	localparam int CONTROL_VSEL_BIT = 0;
	localparam int LFLAG_TIMER0_BIT = 0;
	localparam int LFLAG_TIMER1_BIT = 1;
	localparam int LFLAG_BKP_BIT = 2;
	localparam int LFLAG_DBG_BIT = 3;
	localparam int STATUS_REQ_BIT = 5;
	localparam int STATUS_INSVC_LSB = 8;
	localparam int STATUS_VEC_LSB = 16;

	// natural order indices (0 is natural rank 1)
	localparam logic [4:0] IDX_TIMER0 = 5'h01;
	localparam logic [4:0] IDX_TIMER1 = 5'h03;
	localparam logic [4:0] IDX_BKP = 5'h0F;
	localparam logic [4:0] IDX_DBG = 5'h10;

	// vectors
	localparam logic [7:0] VEC_LOW_LSBS = 8'h03;
	localparam logic [7:0] VEC_BASE_LOW = 8'h00;
	localparam logic [7:0] VEC_BASE_HIGH = 8'hF0;
	localparam logic [15:0] VEC_BKP = 16'hF080;
	localparam logic [15:0] VEC_DBG = 16'hF0C0;
	localparam logic [15:0] VEC_RESET = 16'h0000;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		CLS_LOW,
		CLS_HIGH,
		CLS_DEBUG
	} irq_class_t;

	// raw request inputs, all from logic on the system clock
	typedef struct packed {
		logic pin_group0_request;
		logic pin_group1_request;
		logic timer0_overflow;
		logic timer1_overflow;
		logic uart0_request;
		logic timer2_overflow_flag;
		logic uart2_request;
		logic i2c_master_request;
		logic [1:0] line2_src;
		logic [4:0] line3_src;
		logic line4_src;
		logic watchdog_irq_flag;
		logic [2:0] line6_src;
		logic [2:0] line7_src;
		logic [4:0] line8_src;
		logic breakpoint_match;
		logic debug_port_mode;
		logic host_debug_request;
		logic [7:0] host_debug_id;
	} irq_src_t;

	typedef struct packed {
		logic valid;
		logic [4:0] index;
		irq_class_t cls;
	} irq_winner_t;
endpackage : irq_pkg

// >>> logic/irq_sampler.sv
// register stage that samples every request input on the rising clock edge
`timescale 1ns/1ps
module irq_sampler (
	input wire logic clock,
	input wire logic rst,
	input irq_pkg::irq_src_t src,
	output irq_pkg::irq_src_t sampled
);
	irq_pkg::irq_src_t sample_q;
	irq_pkg::irq_src_t sample_d;

	always_comb begin
		sample_d = src;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			sample_q <= '0;
		end else begin
			sample_q <= sample_d;
		end
	end

	assign sampled = sample_q;
endmodule : irq_sampler

// >>> logic/irq_arbiter.sv
// registered winner selection: debug, breakpoint, high level, low level, then natural order
`timescale 1ns/1ps
module irq_arbiter (
	input wire logic clock,
	input wire logic rst,
	input wire logic [14:0] pending,
	input wire logic [14:0] high_level,
	input wire logic bkp_pending,
	input wire logic dbg_pending,
	output irq_pkg::irq_winner_t winner
);
	irq_pkg::irq_winner_t win_q;
	irq_pkg::irq_winner_t win_d;
	logic [14:0] hi_req;
	logic [14:0] lo_req;

	always_comb begin
		hi_req = pending & high_level;
		lo_req = pending & ~high_level;
		win_d = '0;
		win_d.cls = irq_pkg::CLS_LOW;
		// scanning downward leaves the lowest natural rank as the survivor
		for (int i = irq_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (lo_req[i]) begin
				win_d.valid = 1'b1;
				win_d.index = 5'(i);
			end
		end
		if (|hi_req) begin
			for (int i = irq_pkg::NUM_SRC - 1; i >= 0; i--) begin
				if (hi_req[i]) begin
					win_d.index = 5'(i);
				end
			end
			win_d.valid = 1'b1;
			win_d.cls = irq_pkg::CLS_HIGH;
		end
		if (bkp_pending || dbg_pending) begin
			win_d.valid = 1'b1;
			win_d.cls = irq_pkg::CLS_DEBUG;
			win_d.index = dbg_pending ? irq_pkg::IDX_DBG : irq_pkg::IDX_BKP;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			win_q <= '0;
		end else begin
			win_q <= win_d;
		end
	end

	assign winner = win_q;
endmodule : irq_arbiter

// >>> logic/irq_controller.sv
// interrupt controller top: AXI4-Lite registers, flags, gating, in-service tracking, vector
`timescale 1ns/1ps
// Notes on behaviour
// - fifteen peripheral sources, each assignable to a low or high level
// - every request input is registered on the rising clock edge before arbitration
// - pending enabled requests steer the core to the single best vector
// - sources: seven core peripherals, six shared external lines, two pin groups
// - software writes may clear flags but never set them
// - any high-level request beats every low-level request
// - equal levels resolve by fixed natural order, pin group 0 first
// - vectors 0x0003 plus eight per rank; base select moves upper byte to 0xF0
// - timer 0 and 1 flags clear on service; i2c, breakpoint and debug flags need software
// - each shared line is the OR of its peripheral requests
// - debug and breakpoint outrank all; debug 0xF0C0 beats breakpoint 0xF080
// - debug request when slave is debug port and host id matches
// - breakpoint request raised whenever the breakpoint match occurs
// - debug and breakpoint ignore the global and individual enables
// - each source needs its own enable and the global enable
// - eight-bit enable register resets to zero with documented bit order
// - priority bit 1 means high level, 0 means low level
// - shared-line flags mirror their sources and stay while any is set
// - writes to shared-line flag bits are ignored
module irq_controller (
	input wire logic clock,
	input wire logic rst,
	input irq_pkg::irq_src_t src,
	input wire logic irq_ack,
	input wire logic irq_return,
	output logic irq_request,
	output logic [15:0] vector_address,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	irq_pkg::irq_src_t smp;
	irq_pkg::irq_winner_t win;

	// ---------------- register state
	logic [7:0] enable_q, enable_d;
	logic [7:0] prio_q, prio_d;
	logic [7:0] ext_enable_q, ext_enable_d;
	logic [7:0] ext_prio_q, ext_prio_d;
	logic [7:0] debug_id_q, debug_id_d;
	logic vsel_q, vsel_d;
	logic tf0_q, tf0_d;
	logic tf1_q, tf1_d;
	logic i2c_master_request_q, i2c_master_request_d;
	logic bkp_q, bkp_d;
	logic dbg_q, dbg_d;

	// ---------------- bus state
	logic aw_have_q, aw_have_d;
	logic w_have_q, w_have_d;
	logic [7:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic awready_q, awready_d;
	logic wready_q, wready_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic arready_q, arready_d;
	logic rvalid_q, rvalid_d;
	logic [1:0] rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;

	// ---------------- service state
	logic [2:0] insvc_q, insvc_d;
	logic req_q, req_d;
	logic [15:0] vec_q, vec_d;

	// ---------------- combinational helpers
	logic line2, line3, line4, line6, line7, line8;
	logic [14:0] raw_flags;
	logic [14:0] enables;
	logic [14:0] pending;
	logic dbg_hit;
	logic aw_take, w_take, ar_take, do_write;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_byte0;
	logic wr_hit;
	logic rd_hit;
	logic [31:0] rd_val;
	logic [7:0] ext_flag_view;
	logic [7:0] local_flag_view;
	logic take;
	logic ack_tf0, ack_tf1;
	logic [2:0] insvc_mid;
	logic blocked;

	irq_sampler u_sampler (
		.clock(clock),
		.rst(rst),
		.src(src),
		.sampled(smp)
	);

	always_comb begin
		// shared lines are plain ORs, so they clear only when every source has cleared
		line2 = |smp.line2_src;
		line3 = |smp.line3_src;
		line4 = smp.line4_src;
		line6 = |smp.line6_src;
		line7 = |smp.line7_src;
		line8 = |smp.line8_src;
		// seven core sources, six shared lines, two pin groups in natural order
		raw_flags = {line8, line7, line6, smp.watchdog_irq_flag, line4, line3, line2,
			i2c_master_request_q, smp.uart2_request, smp.timer2_overflow_flag, smp.uart0_request,
			tf1_q, smp.pin_group1_request, tf0_q, smp.pin_group0_request};
		enables = {ext_enable_q, enable_q[6:0]};
		pending = raw_flags & enables & {15{enable_q[irq_pkg::ENABLE_GLOBAL_BIT]}};
		dbg_hit = smp.debug_port_mode && smp.host_debug_request
			&& (smp.host_debug_id == debug_id_q);
	end

	irq_arbiter u_arbiter (
		.clock(clock),
		.rst(rst),
		.pending(pending),
		.high_level({ext_prio_q, prio_q[6:0]}),
		.bkp_pending(bkp_q),
		.dbg_pending(dbg_q),
		.winner(win)
	);

	// ---------------- AXI4-Lite write and read channels
	always_comb begin
		aw_take = s_axi_awvalid && awready_q;
		w_take = s_axi_wvalid && wready_q;
		ar_take = s_axi_arvalid && arready_q;
		awaddr_d = aw_take ? s_axi_awaddr[7:0] : awaddr_q;
		wdata_d = w_take ? s_axi_wdata : wdata_q;
		wstrb_d = w_take ? s_axi_wstrb : wstrb_q;
		wr_addr = awaddr_d;
		wr_data = wdata_d;
		wr_strb = wstrb_d;
		do_write = (aw_have_q || aw_take) && (w_have_q || w_take);
		aw_have_d = (aw_have_q || aw_take) && !do_write;
		w_have_d = (w_have_q || w_take) && !do_write;
		bvalid_d = do_write || (bvalid_q && !s_axi_bready);
		awready_d = !aw_have_d && !bvalid_d;
		wready_d = !w_have_d && !bvalid_d;
		case (wr_addr)
			irq_pkg::OFS_ENABLE, irq_pkg::OFS_PRIORITY, irq_pkg::OFS_EXT_ENABLE,
			irq_pkg::OFS_EXT_PRIORITY, irq_pkg::OFS_EXT_FLAG, irq_pkg::OFS_CONTROL,
			irq_pkg::OFS_LOCAL_FLAG, irq_pkg::OFS_DEBUG_ID, irq_pkg::OFS_STATUS: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
		bresp_d = do_write ? (wr_hit ? irq_pkg::RESP_OKAY : irq_pkg::RESP_SLVERR) : bresp_q;
		wr_byte0 = do_write && wr_strb[0];
	end

	always_comb begin
		ext_flag_view = {line8, line7, line6, 1'b0, line4, line3, line2, i2c_master_request_q};
		local_flag_view = {4'h0, dbg_q, bkp_q, tf1_q, tf0_q};
		rd_hit = 1'b1;
		case (s_axi_araddr[7:0])
			irq_pkg::OFS_ENABLE: rd_val = {24'h000000, enable_q};
			irq_pkg::OFS_PRIORITY: rd_val = {25'h0000000, prio_q[6:0]};
			irq_pkg::OFS_EXT_ENABLE: rd_val = {24'h000000, ext_enable_q};
			irq_pkg::OFS_EXT_PRIORITY: rd_val = {24'h000000, ext_prio_q};
			irq_pkg::OFS_EXT_FLAG: rd_val = {24'h000000, ext_flag_view};
			irq_pkg::OFS_CONTROL: rd_val = {31'h00000000, vsel_q};
			irq_pkg::OFS_LOCAL_FLAG: rd_val = {24'h000000, local_flag_view};
			irq_pkg::OFS_DEBUG_ID: rd_val = {24'h000000, debug_id_q};
			irq_pkg::OFS_STATUS: rd_val = {vec_q, 5'h00, insvc_q, 2'h0, req_q, win.index};
			default: begin
				rd_val = 32'h00000000;
				rd_hit = 1'b0;
			end
		endcase
		rvalid_d = ar_take || (rvalid_q && !s_axi_rready);
		arready_d = !rvalid_d;
		rdata_d = ar_take ? rd_val : rdata_q;
		rresp_d = ar_take ? (rd_hit ? irq_pkg::RESP_OKAY : irq_pkg::RESP_SLVERR) : rresp_q;
	end

	// ---------------- software registers and flags
	always_comb begin
		take = irq_ack && req_q;
		ack_tf0 = take && (win.cls != irq_pkg::CLS_DEBUG) && (win.index == irq_pkg::IDX_TIMER0);
		ack_tf1 = take && (win.cls != irq_pkg::CLS_DEBUG) && (win.index == irq_pkg::IDX_TIMER1);
		enable_d = enable_q;
		prio_d = prio_q;
		ext_enable_d = ext_enable_q;
		ext_prio_d = ext_prio_q;
		debug_id_d = debug_id_q;
		vsel_d = vsel_q;
		tf0_d = tf0_q;
		tf1_d = tf1_q;
		i2c_master_request_d = i2c_master_request_q;
		bkp_d = bkp_q;
		dbg_d = dbg_q;
		if (wr_byte0) begin
			case (wr_addr)
				irq_pkg::OFS_ENABLE: enable_d = wr_data[7:0];
				irq_pkg::OFS_PRIORITY: prio_d = wr_data[7:0];
				irq_pkg::OFS_EXT_ENABLE: ext_enable_d = wr_data[7:0];
				irq_pkg::OFS_EXT_PRIORITY: ext_prio_d = wr_data[7:0];
				irq_pkg::OFS_DEBUG_ID: debug_id_d = wr_data[7:0];
				irq_pkg::OFS_CONTROL: vsel_d = wr_data[irq_pkg::CONTROL_VSEL_BIT];
				// writing 0 clears a flag, writing 1 leaves it alone
				irq_pkg::OFS_EXT_FLAG: begin
					i2c_master_request_d = i2c_master_request_q && wr_data[0];
				end
				irq_pkg::OFS_LOCAL_FLAG: begin
					tf0_d = tf0_q && wr_data[irq_pkg::LFLAG_TIMER0_BIT];
					tf1_d = tf1_q && wr_data[irq_pkg::LFLAG_TIMER1_BIT];
					bkp_d = bkp_q && wr_data[irq_pkg::LFLAG_BKP_BIT];
					dbg_d = dbg_q && wr_data[irq_pkg::LFLAG_DBG_BIT];
				end
				default: ;
			endcase
		end
		if (ack_tf0) tf0_d = 1'b0;
		if (ack_tf1) tf1_d = 1'b0;
		// hardware sets last so an event in the clearing cycle is kept
		if (smp.timer0_overflow) tf0_d = 1'b1;
		if (smp.timer1_overflow) tf1_d = 1'b1;
		if (smp.i2c_master_request) i2c_master_request_d = 1'b1;
		if (smp.breakpoint_match) bkp_d = 1'b1;
		if (dbg_hit) dbg_d = 1'b1;
	end

	// ---------------- in-service tracking and core request
	always_comb begin
		insvc_mid = insvc_q;
		// return retires the handler of the highest active level
		if (irq_return) begin
			if (insvc_q[2]) insvc_mid[2] = 1'b0;
			else if (insvc_q[1]) insvc_mid[1] = 1'b0;
			else insvc_mid[0] = 1'b0;
		end
		insvc_d = insvc_mid;
		if (take) insvc_d[win.cls] = 1'b1;
		// a request needs a strictly higher level than anything in service
		case (win.cls)
			irq_pkg::CLS_LOW: blocked = |insvc_d;
			irq_pkg::CLS_HIGH: blocked = |insvc_d[2:1];
			irq_pkg::CLS_DEBUG: blocked = insvc_d[2];
			default: blocked = 1'b1;
		endcase
		req_d = win.valid && !blocked;
		if (win.index == irq_pkg::IDX_DBG) vec_d = irq_pkg::VEC_DBG;
		else if (win.index == irq_pkg::IDX_BKP) vec_d = irq_pkg::VEC_BKP;
		else vec_d = {vsel_q ? irq_pkg::VEC_BASE_HIGH : irq_pkg::VEC_BASE_LOW,
			win.index, irq_pkg::VEC_LOW_LSBS[2:0]};
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			enable_q <= irq_pkg::RST_ENABLE;
			prio_q <= irq_pkg::RST_PRIORITY;
			ext_enable_q <= irq_pkg::RST_EXT_ENABLE;
			ext_prio_q <= irq_pkg::RST_EXT_PRIORITY;
			debug_id_q <= irq_pkg::RST_DEBUG_ID;
			vsel_q <= 1'b0;
			tf0_q <= 1'b0;
			tf1_q <= 1'b0;
			i2c_master_request_q <= 1'b0;
			bkp_q <= 1'b0;
			dbg_q <= 1'b0;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= irq_pkg::RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rresp_q <= irq_pkg::RESP_OKAY;
			rdata_q <= 32'h00000000;
			insvc_q <= 3'h0;
			req_q <= 1'b0;
			vec_q <= irq_pkg::VEC_RESET;
		end else begin
			enable_q <= enable_d;
			prio_q <= prio_d;
			ext_enable_q <= ext_enable_d;
			ext_prio_q <= ext_prio_d;
			debug_id_q <= debug_id_d;
			vsel_q <= vsel_d;
			tf0_q <= tf0_d;
			tf1_q <= tf1_d;
			i2c_master_request_q <= i2c_master_request_d;
			bkp_q <= bkp_d;
			dbg_q <= dbg_d;
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			insvc_q <= insvc_d;
			req_q <= req_d;
			vec_q <= vec_d;
		end
	end

	assign irq_request = req_q;
	assign vector_address = vec_q;
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
endmodule : irq_controller

// >>> tb/irq_controller_assertions.sv
// bound checker watching the interrupt controller ports
`timescale 1ns/1ps
module irq_controller_check (
	input wire logic clock,
	input wire logic rst,
	input wire irq_pkg::irq_src_t src,
	input wire logic irq_ack,
	input wire logic irq_return,
	input wire logic irq_request,
	input wire logic [15:0] vector_address,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic dbg_busy_q;
	logic dbg_busy_d;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// a running debug handler blocks new debug-class service, so track it from the ack
	always_comb begin
		dbg_busy_d = dbg_busy_q;
		if (irq_return) dbg_busy_d = 1'b0;
		if (irq_ack && irq_request && vector_address[15:7] == 9'h1E1) dbg_busy_d = 1'b1;
	end
	always_ff @(posedge clock) begin
		if (rst) dbg_busy_q <= 1'b0;
		else dbg_busy_q <= dbg_busy_d;
	end

	chk_reset_quiet: assert property ($fell(rst) |->
		!irq_request && !s_axi_bvalid && !s_axi_rvalid && !s_axi_awready)
		else $error("outputs busy right after reset");
	chk_vector_form: assert property (irq_request |->
		vector_address inside {16'hF080, 16'hF0C0} || (vector_address[2:0] == 3'h3 &&
		vector_address[7:3] <= 5'h0E && vector_address[15:8] inside {8'h00, 8'hF0}))
		else $error("vector outside the table");
	chk_debug_vector: assert property (src.breakpoint_match && !dbg_busy_q |->
		##[1:6] (irq_request && vector_address[15:7] == 9'h1E1))
		else $error("breakpoint not vectored");
	chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data dropped");
	chk_read_turn: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |=> s_axi_bvalid)
		else $error("write answer late");
	chk_unmapped_read: assert property (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr[7:0] == 8'h00 |=> s_axi_rresp == irq_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read accepted");
	chk_ready_back: assert property (s_axi_bvalid && s_axi_bready |=>
		##[0:2] (s_axi_awready && s_axi_wready))
		else $error("write channel not reopened");
endmodule : irq_controller_check

bind irq_controller irq_controller_check i_irq_controller_check (.*);

// >>> tb/cpu_core_model.sv
// core sequencer model: takes a shown vector, runs a short handler, returns
`timescale 1ns/1ps
module cpu_core_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic take_en,
	input wire logic irq_request,
	output logic irq_ack,
	output logic irq_return
);
	logic [3:0] left_q;
	// one handler at a time; no request is acked until the running handler has returned
	always_ff @(posedge clock) begin
		irq_ack <= 1'b0;
		irq_return <= 1'b0;
		if (rst) begin
			left_q <= 4'h0;
		end else if (left_q != 4'h0) begin
			left_q <= left_q - 4'h1;
			irq_return <= left_q == 4'h1;
		end else if (take_en && irq_request && !irq_ack) begin
			irq_ack <= 1'b1;
			left_q <= 4'h6;
		end
	end
endmodule : cpu_core_model

// >>> tb/tb_irq_controller.sv
// self-checking bench for the interrupt controller with a core model on the far side
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_irq_controller;
	logic clock, rst, irq_ack, irq_return, irq_request, take_en;
	logic [15:0] vector_address;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	irq_pkg::irq_src_t src;
	int bad_count, cmp_count;

	irq_controller i_irq_controller (.*);
	cpu_core_model i_cpu_core_model (.*);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test

	// bready is raised late on purpose so the slave has to hold its answer
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic [1:0] r = irq_pkg::RESP_OKAY);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!done && n < 50) begin
			@(posedge clock);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			done = s_axi_bvalid && s_axi_bready;
			s_axi_bready <= !done && n >= 2;
		end
		`CHK({done, s_axi_bresp}, {1'b1, r})
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] r = irq_pkg::RESP_OKAY);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		while (!done && n < 50) begin
			@(posedge clock);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			done = s_axi_rvalid && s_axi_rready;
			s_axi_rready <= !done && n >= 2;
		end
		`CHK({done, s_axi_rresp, s_axi_rdata}, {1'b1, r, e})
	endtask : rd

	task automatic want(input logic [15:0] v);
		int n;
		n = 0;
		while (!(irq_request === 1'b1 && vector_address === v) && n < 20) begin
			@(posedge clock);
			n++;
		end
		`CHK({irq_request, vector_address}, {1'b1, v})
	endtask : want

	task automatic quiet();
		repeat (8) @(posedge clock);
		`CHK(irq_request, 1'b0)
	endtask : quiet

	task automatic t_regs();
		rd(8'hA8, 32'h0);
		wr(8'hA8, 8'hA5);
		wr(8'h00, 8'h5A, irq_pkg::RESP_SLVERR);
		rd(8'hA8, 32'hA5);
		rd(8'h00, 32'h0, irq_pkg::RESP_SLVERR);
		$display("register test done");
	endtask : t_regs

	task automatic t_order();
		wr(8'hA8, 8'hFF);
		src.pin_group1_request <= 1'b1;
		src.uart0_request <= 1'b1;
		want(16'h0013);
		wr(8'hB8, 8'h10);
		want(16'h0023);
		wr(8'hC0, 8'h01);
		want(16'hF023);
		wr(8'hA8, 8'h7F);
		quiet();
		src.pin_group1_request <= 1'b0;
		src.uart0_request <= 1'b0;
		wr(8'hC0, 8'h00);
		wr(8'hB8, 8'h00);
		$display("order test done");
	endtask : t_order

	task automatic t_debug();
		wr(8'hA8, 8'h00);
		src.breakpoint_match <= 1'b1;
		@(posedge clock);
		src.breakpoint_match <= 1'b0;
		want(16'hF080);
		wr(8'hC8, 8'h5A);
		src.debug_port_mode <= 1'b1;
		src.host_debug_id <= 8'h5A;
		src.host_debug_request <= 1'b1;
		@(posedge clock);
		src.host_debug_request <= 1'b0;
		want(16'hF0C0);
		wr(8'hC4, 8'h00);
		quiet();
		$display("debug test done");
	endtask : t_debug

	task automatic t_timer();
		wr(8'hA8, 8'h82);
		src.timer0_overflow <= 1'b1;
		@(posedge clock);
		src.timer0_overflow <= 1'b0;
		want(16'h000B);
		rd(8'hC4, 32'h1);
		take_en <= 1'b1;
		repeat (12) @(posedge clock);
		rd(8'hC4, 32'h0);
		take_en <= 1'b0;
		wr(8'hC4, 8'hFF);
		rd(8'hC4, 32'h0);
		$display("timer test done");
	endtask : t_timer

	task automatic t_shared();
		wr(8'hE8, 8'h80);
		wr(8'hA8, 8'h80);
		src.line8_src <= 5'h04;
		want(16'h0073);
		wr(8'h90, 8'h00);
		rd(8'h90, 32'h80);
		src.line8_src <= 5'h00;
		repeat (4) @(posedge clock);
		rd(8'h90, 32'h0);
		$display("shared line test done");
	endtask : t_shared

	// one low handler taken; a same-level request waits, a high one is still requested
	task automatic t_nest();
		wr(8'hA8, 8'h91);
		wr(8'hB8, 8'h10);
		src.pin_group0_request <= 1'b1;
		want(16'h0003);
		take_en <= 1'b1;
		@(posedge clock);
		take_en <= 1'b0;
		src.uart0_request <= 1'b1;
		repeat (2) @(posedge clock);
		`CHK(irq_request, 1'b0)
		repeat (3) @(posedge clock);
		`CHK({irq_request, vector_address}, {1'b1, 16'h0023})
		// status read lands while the low handler is still running
		rd(8'hCC, 32'h00230124);
		src.pin_group0_request <= 1'b0;
		src.uart0_request <= 1'b0;
		repeat (8) @(posedge clock);
		wr(8'hB8, 8'h00);
		$display("nesting test done");
	endtask : t_nest

	initial begin
		rst = 1'b1;
		take_en = 1'b0;
		src = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		s_axi_wstrb = 4'hF;
		bad_count = 0;
		cmp_count = 0;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		t_regs();
		t_order();
		t_debug();
		t_timer();
		t_shared();
		t_nest();
		stop_test();
	end

	initial begin
		#100000;
		bad_count++;
		stop_test();
	end
endmodule : tb_irq_controller
